// ---- src/sipo_pkg.sv ----
/*
 Shared constants for the serial-in latched driver link: stage count,
 reset values and the timing counts that pace the controller.
 Assumes a single 100 MHz system clock on both ends.
*/
package sipo_pkg;
  localparam int STAGES = 10;
  localparam int CLK_PERIOD_NS = 10;
  // Fastest shift clock the device accepts, in MHz.
  localparam int SHIFT_MHZ_MAX = 10;
  localparam int SHIFT_PERIOD_NS = 1000 / SHIFT_MHZ_MAX;
  // Half period of the shift clock, rounded up so the rate never exceeds the limit.
  localparam int SHIFT_HALF_CYC = (SHIFT_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHIFT_TO_STROBE_NS = 100;
  localparam int SHIFT_TO_STROBE_CYC = (SHIFT_TO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_WIDTH_NS = 50;
  localparam int STROBE_WIDTH_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 32;
  localparam logic [STAGES-1:0] STAGE_RESET = 10'h000;
  localparam int CNT_W = 8;
endpackage

// ---- src/sipo_link_if.sv ----
/*
 Pin bundle between the controller and the latched driver.
 Assumes both ends run on the same sys_clk; pins are plain levels.
*/
`timescale 1ns/1ps
interface sipo_link_if;
  logic serial_in;
  logic shift_clk;
  logic strobe;
  logic output_blank_pin;
  logic serial_out;
  modport device (
    input serial_in,
    input shift_clk,
    input strobe,
    input output_blank_pin,
    output serial_out
  );
  modport ctrl (
    output serial_in,
    output shift_clk,
    output strobe,
    output output_blank_pin,
    input serial_out
  );
endinterface

// ---- src/word_fifo.sv ----
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock and a clock enable that freezes all state.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("word_fifo: DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// ---- src/latched_driver.sv ----
/*
 Device end: ten-stage shift register, transparent-style latches and
 blanked source outputs.
 // Contract
 // RULE1: Ten stages, each with latch and driver.
 // RULE2: Rising shift clock captures serial input.
 // RULE3: Later rising edges shift toward output.
 // RULE4: Controller sets data before raising clock.
 // RULE5: High strobe copies stages into latches.
 // RULE6: Latches follow while high, hold when low.
 // RULE7: Strobe tied high needs blanking during shifting.
 // RULE8: Blanking high forces all outputs low.
 // RULE9: Blanking never alters latch contents.
 // RULE10: Unblanked outputs follow their latches.
 // RULE11: Wait 100 ns from shift to strobe.
 // RULE12: Shift clock up to 10 MHz supported.
 // RULE13: Serial output shows last stage.
 Assumes link pins are synchronous to sys_clk; the shift clock is sampled
 and its rising edge detected, so it must stay well below sys_clk.
*/
`timescale 1ns/1ps
module latched_driver #(
  parameter int STAGES = sipo_pkg::STAGES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  sipo_link_if.device link,
  output logic [STAGES-1:0] driver_outputs
);
  initial
  begin
    if (STAGES < 2)
      $error("latched_driver: STAGES must be at least 2");
  end
  // RULE1: stage storage
  logic [STAGES-1:0] shift_q;
  logic [STAGES-1:0] latch_q;
  logic clk_prev_q;
  logic sout_q;
  // RULE12: edge detection runs at sys_clk, far above 10 MHz
  wire shift_edge = link.shift_clk && !clk_prev_q;
  // RULE2: first stage takes serial input; RULE3 shifts rest up
  wire [STAGES-1:0] shift_d = shift_edge ? {shift_q[STAGES-2:0], link.serial_in} : shift_q;
  // RULE5: high strobe copies the settled register; RULE6 holds otherwise
  wire [STAGES-1:0] latch_d = link.strobe ? shift_d : latch_q;
  // RULE8: blanking forces low; RULE10 passes latches when low
  wire [STAGES-1:0] out_d = link.output_blank_pin ? '0 : latch_d;
  assign link.serial_out = sout_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= sipo_pkg::STAGE_RESET;
      latch_q <= sipo_pkg::STAGE_RESET;
      clk_prev_q <= 1'b0;
      sout_q <= 1'b0;
      driver_outputs <= '0;
    end
    else if (clk_en)
    begin
      clk_prev_q <= link.shift_clk;
      shift_q <= shift_d;
      // RULE9: latch update ignores blanking
      latch_q <= latch_d;
      // RULE13: serial output is last stage
      sout_q <= shift_d[STAGES-1];
      driver_outputs <= out_d;
    end
  end
endmodule

// ---- src/driver_ctrl.sv ----
/*
 Controller end: takes frames from a FIFO, shifts them out MSB first at a
 bounded rate, waits, then pulses the strobe. Blanking is a user level.
 Assumes the device samples pins on the same sys_clk.
*/
`timescale 1ns/1ps
module driver_ctrl #(
  parameter int STAGES = sipo_pkg::STAGES,
  parameter int DEPTH = sipo_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [STAGES-1:0] frame_data,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire logic blank_req,
  output logic busy,
  output logic cascade_in,
  sipo_link_if.ctrl link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_STRB = 4'b1000
  } state_e;
  state_e state_q;
  logic [STAGES-1:0] word_q;
  logic [sipo_pkg::CNT_W-1:0] cnt_q;
  logic [$clog2(STAGES+1)-1:0] bits_q;
  logic sin_q;
  logic sclk_q;
  logic strb_q;
  logic blank_q;
  logic casc_q;
  logic busy_q;
  logic [STAGES-1:0] f_data;
  logic f_valid;
  wire f_ready = clk_en && state_q == ST_IDLE;
  word_fifo #(.WIDTH(STAGES), .DEPTH(DEPTH)) fifo_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_data(frame_data),
    .in_valid(frame_valid),
    .in_ready(frame_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
  localparam logic [sipo_pkg::CNT_W-1:0] HALF = sipo_pkg::CNT_W'(sipo_pkg::SHIFT_HALF_CYC - 1);
  localparam logic [sipo_pkg::CNT_W-1:0] GAP = sipo_pkg::CNT_W'(sipo_pkg::SHIFT_TO_STROBE_CYC);
  localparam logic [sipo_pkg::CNT_W-1:0] SW = sipo_pkg::CNT_W'(sipo_pkg::STROBE_WIDTH_CYC - 1);
  wire cnt_done = cnt_q == '0;
  wire last_bit = bits_q == '0;
  assign link.serial_in = sin_q;
  assign link.shift_clk = sclk_q;
  assign link.strobe = strb_q;
  assign link.output_blank_pin = blank_q;
  assign cascade_in = casc_q;
  assign busy = busy_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      word_q <= '0;
      cnt_q <= '0;
      bits_q <= '0;
      sin_q <= 1'b0;
      sclk_q <= 1'b0;
      strb_q <= 1'b0;
      blank_q <= 1'b1;
      casc_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else if (clk_en)
    begin
      blank_q <= blank_req;
      casc_q <= link.serial_out;
      unique case (state_q)
        ST_IDLE:
        begin
          if (f_valid)
          begin
            // RULE4: data set while clock is low
            sin_q <= f_data[STAGES-1];
            word_q <= {f_data[STAGES-2:0], 1'b0};
            bits_q <= ($clog2(STAGES+1))'(STAGES - 1);
            cnt_q <= HALF;
            busy_q <= 1'b1;
            state_q <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (cnt_done)
          begin
            sclk_q <= 1'b1;
            cnt_q <= HALF;
            state_q <= ST_HIGH;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_HIGH:
        begin
          // RULE12: each half period lasts at least 50 ns
          if (cnt_done)
          begin
            sclk_q <= 1'b0;
            if (last_bit)
            begin
              // RULE11: gap before strobe
              cnt_q <= GAP;
              state_q <= ST_STRB;
            end
            else
            begin
              sin_q <= word_q[STAGES-1];
              word_q <= {word_q[STAGES-2:0], 1'b0};
              bits_q <= bits_q - 1'b1;
              cnt_q <= HALF;
              state_q <= ST_LOW;
            end
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_STRB:
        begin
          // RULE7: strobe only after shifting
          if (!strb_q && cnt_done)
          begin
            strb_q <= 1'b1;
            cnt_q <= SW;
          end
          else if (strb_q && cnt_done)
          begin
            strb_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
      endcase
    end
  end
endmodule

// ---- tb/sipo_link_chk.sv ----
/* Checker for the pins between controller and latched driver.
 Assumes one sys_clk and asynchronous active-low rst_b. */
`timescale 1ns/1ps
module sipo_link_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic strobe,
  input wire logic output_blank_pin,
  input wire logic serial_out
);
  logic [7:0] low_q;
  // Counts quiet clock cycles, so the strobe spacing can be judged.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      low_q <= 8'h00;
    else if (shift_clk)
      low_q <= 8'h00;
    else if (low_q != 8'hFF)
      low_q <= low_q + 8'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_out_hold; !$rose(shift_clk) |=> $stable(serial_out); endproperty
  property p_clk_hi; $rose(shift_clk) |-> shift_clk [*5]; endproperty
  property p_clk_lo; $fell(shift_clk) |-> !shift_clk [*5]; endproperty
  property p_setup; $rose(shift_clk) |-> $stable(serial_in); endproperty
  // The next bit may change on the very edge that lowers the clock.
  property p_hold; shift_clk |-> $stable(serial_in); endproperty
  property p_gap; $rose(strobe) |-> low_q >= 8'h0A; endproperty
  property p_width; $rose(strobe) |-> strobe [*5] ##1 !strobe; endproperty
  property p_apart; strobe |-> !shift_clk; endproperty
  a_out_hold: assert property (p_out_hold) else $error("serial out moved");
  a_clk_hi: assert property (p_clk_hi) else $error("clock high too short");
  a_clk_lo: assert property (p_clk_lo) else $error("clock low too short");
  a_setup: assert property (p_setup) else $error("data moved at clock");
  a_hold: assert property (p_hold) else $error("data moved while high");
  a_gap: assert property (p_gap) else $error("strobe too soon");
  a_width: assert property (p_width) else $error("strobe width wrong");
  a_apart: assert property (p_apart) else $error("strobe during shift");
  c_strobe: cover property ($rose(strobe));
  c_unblank: cover property ($fell(output_blank_pin));
  c_one: cover property ($rose(shift_clk) ##0 serial_in);
endmodule

// ---- tb/tb.sv ----
/* Bench joining controller and latched driver through the link.
 Assumes the design package and interface are compiled first. */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] frame_data = 10'h000;
  logic frame_valid = 1'b0;
  logic blank_req = 1'b1;
  logic frame_ready;
  logic busy;
  logic cascade_in;
  logic [sipo_pkg::STAGES-1:0] driver_outputs;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  int m;
  sipo_link_if link ();
  always #5 sys_clk = ~sys_clk;
  driver_ctrl u_driver_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .blank_req(blank_req), .busy(busy), .cascade_in(cascade_in), .link(link));
  latched_driver u_latched_driver (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .link(link), .driver_outputs(driver_outputs));
  sipo_link_chk u_sipo_link_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .serial_in(link.serial_in), .shift_clk(link.shift_clk), .strobe(link.strobe),
    .output_blank_pin(link.output_blank_pin), .serial_out(link.serial_out));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [9:0] v);
    @(posedge sys_clk);
    frame_data <= v;
    frame_valid <= 1'b1;
    @(negedge sys_clk);
    while (frame_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    frame_valid <= 1'b0;
  endtask
  // Idle for three cycles in a row, since the controller may idle one cycle between frames.
  task automatic wait_idle;
    m = 0;
    while (m < 3)
    begin
      @(negedge sys_clk);
      m = (busy === 1'b0) ? m + 1 : 0;
    end
  endtask
  task automatic set_blank(input logic b);
    @(posedge sys_clk);
    blank_req <= b;
    repeat (4) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk(driver_outputs, 10'h000);
    set_blank(1'b0);
    push(10'h2A5);
    wait_idle;
    chk(driver_outputs, 10'h2A5);
    chk({9'h000, link.serial_out}, 10'h001);
    chk({9'h000, cascade_in}, 10'h001);
    $display("test shift done");
    push(10'h15A);
    repeat (60) @(negedge sys_clk);
    chk(driver_outputs, 10'h2A5);
    wait_idle;
    chk(driver_outputs, 10'h15A);
    chk({9'h000, link.serial_out}, 10'h000);
    $display("test hold done");
    set_blank(1'b1);
    chk(driver_outputs, 10'h000);
    push(10'h3FF);
    wait_idle;
    chk(driver_outputs, 10'h000);
    set_blank(1'b0);
    chk(driver_outputs, 10'h3FF);
    $display("test blank done");
    @(posedge sys_clk);
    n = 0;
    frame_valid <= 1'b1;
    frame_data <= 10'h000;
    @(negedge sys_clk);
    while (frame_ready === 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
      frame_data <= n[9:0];
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    chk(10'(n), 10'(sipo_pkg::FIFO_DEPTH + 1));
    wait_idle;
    chk(driver_outputs, 10'(n - 1));
    $display("test fill done");
    print_verdict;
  end
endmodule
